//--- src/spmp_map.svh
// Purpose: constants for the serial port block
// Assumes: 25 MHz core clock
// Notes:   reset values of the register-like ports live in the module
`ifndef SPMP_MAP_SVH
`define SPMP_MAP_SVH
`define SPMP_BITS        4'h8
`define SPMP_CNT_W       12
`define SPMP_TXE_RESET   1'b1
`define SPMP_SEL_IDLE    1'b1
`endif

//--- src/spmp_pkg.sv
// Purpose: types for the serial port block
// Assumes: spmp_map.svh supplies the numbers
// Notes:   config travels as one packed struct
package spmp_pkg;
  typedef struct packed {
    logic       portEnable;
    logic       masterSelect;
    logic       clockPolarity;
    logic       clockPhase;
    logic       shiftDirection;
    logic       singleWireSelect;
    logic       bidirOutputEnable;
    logic       modeFaultEnable;
    logic       selectOutputEnable;
    logic       receiveFaultIrqEnable;
    logic       transmitIrqEnable;
    logic [2:0] prescaleSelect;
    logic [2:0] rateSelect;
  } spmp_cfg_s;
  typedef enum logic [2:0] {
    SPMP_IDLE  = 3'b001,
    SPMP_SHIFT = 3'b010,
    SPMP_DONE  = 3'b100
  } spmp_state_e;
endpackage

//--- src/spmp_port.sv
// Purpose: serial peripheral port, master or slave, one shifter
// Assumes: pins sampled synchronously to core_clk; stop inputs from system
// Notes:   slave clock edges are detected by oversampling the pin
`timescale 1ns/10ps
`include "spmp_map.svh"

module spmp_port
  import spmp_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire spmp_pkg::spmp_cfg_s cfg,
  input  wire logic             stopMode,
  input  wire logic             deepStopWake,
  input  wire logic             txWrite,
  input  wire logic [7:0]       txData,
  input  wire logic             rxRead,
  input  wire logic             faultClear,
  output logic [7:0]            rxData,
  output logic                  receiveFullFlag,
  output logic                  transmitEmptyFlag,
  output logic                  modeFaultFlag,
  output logic                  masterActive,
  output logic                  irqReq,
  input  wire logic             sckIn,
  output logic                  sckOut,
  output logic                  sckOe_n,
  input  wire logic             mosiIn,
  output logic                  mosiOut,
  output logic                  mosiOe_n,
  input  wire logic             misoIn,
  output logic                  misoOut,
  output logic                  misoOe_n,
  input  wire logic             selIn,
  output logic                  selOut,
  output logic                  selOe_n
);
  import spmp_pkg::*;

  typedef struct packed {
    spmp_state_e            state;
    logic [7:0]             txBuf;
    logic                   txFull;
    logic [7:0]             shifter;
    logic [7:0]             rxBuf;
    logic                   rxFull;
    logic                   fault;
    logic                   masterOn;
    logic [`SPMP_CNT_W-1:0] divCnt;
    logic [4:0]             edges;
    logic                   txBit;
    logic                   sck;
    logic                   inBit;
    logic                   sckSeen;
    logic                   sel;
    logic                   irq;
    logic [7:0]             outPins;
  } spmp_st_s;

  spmp_st_s st_reg;
  spmp_st_s st_next;

  // half bit period in core clocks: (pre+1) * 2^(rate+1) / 2
  function automatic logic [`SPMP_CNT_W-1:0] halfPeriod(
    input logic [2:0] pre,
    input logic [2:0] rate
  );
    logic [`SPMP_CNT_W-1:0] base;
    base = `SPMP_CNT_W'({1'b0, pre} + 4'h1);
    return base << rate;
  endfunction

  function automatic logic outBit(input logic [7:0] v, input logic lsb);
    return lsb ? v[0] : v[7];
  endfunction

  function automatic logic [7:0] shiftIn(input logic [7:0] v,
                                         input logic lsb, input logic b);
    return lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  logic en;
  logic isMaster;
  logic dataIn;
  logic slvSel;
  logic sampleEdge;
  logic shiftEdge;
  logic lead;

  always_comb begin
    st_next  = st_reg;
    en       = cfg.portEnable & ~stopMode;
    isMaster = cfg.masterSelect & ~st_reg.fault;
    // master samples miso (or its single data pin), slave mosi/miso
    if (isMaster) begin
      dataIn = cfg.singleWireSelect ? mosiIn : misoIn;
    end else begin
      dataIn = cfg.singleWireSelect ? misoIn : mosiIn;
    end
    slvSel     = ~selIn;
    sampleEdge = 1'b0;
    shiftEdge  = 1'b0;
    lead       = 1'b0;
    st_next.sckSeen = sckIn ^ cfg.clockPolarity;
    st_next.inBit   = dataIn;
    if (txWrite && en) begin
      st_next.txBuf  = txData;
      st_next.txFull = 1'b1;
    end
    if (rxRead) begin
      st_next.rxFull = 1'b0;
    end
    if (faultClear && !(isMaster && cfg.modeFaultEnable &&
                        !cfg.selectOutputEnable && !selIn)) begin
      st_next.fault = 1'b0;
    end
    case (st_reg.state)
      SPMP_IDLE: begin
        st_next.sck   = 1'b0;
        st_next.edges = 5'h0;
        st_next.sel   = `SPMP_SEL_IDLE;
        if (en && isMaster && st_reg.txFull) begin
          st_next.shifter = st_reg.txBuf;
          st_next.txBit   = outBit(st_reg.txBuf, cfg.shiftDirection);
          st_next.txFull  = txWrite;
          st_next.divCnt  = halfPeriod(cfg.prescaleSelect, cfg.rateSelect);
          st_next.sel     = 1'b0;
          st_next.state   = SPMP_SHIFT;
        end else if (en && !isMaster && slvSel) begin
          st_next.shifter = st_reg.txFull ? st_reg.txBuf : st_reg.shifter;
          st_next.txBit   = outBit(st_next.shifter, cfg.shiftDirection);
          st_next.txFull  = txWrite;
          st_next.state   = SPMP_SHIFT;
        end
      end
      SPMP_SHIFT: begin
        if (isMaster) begin
          if (st_reg.divCnt == `SPMP_CNT_W'(1)) begin
            st_next.divCnt = halfPeriod(cfg.prescaleSelect, cfg.rateSelect);
            st_next.sck    = ~st_reg.sck;
            st_next.edges  = st_reg.edges + 5'h1;
            lead           = ~st_reg.sck;
          end else begin
            st_next.divCnt = st_reg.divCnt - `SPMP_CNT_W'(1);
          end
        end else if (slvSel) begin
          // a deselected slave sees no edges at all
          lead = st_next.sckSeen & ~st_reg.sckSeen;
          if (st_next.sckSeen != st_reg.sckSeen) begin
            st_next.edges = st_reg.edges + 5'h1;
          end
        end
        if (st_next.edges != st_reg.edges) begin
          sampleEdge = (lead != cfg.clockPhase);
          shiftEdge  = ~sampleEdge;
        end
        if (sampleEdge) begin
          st_next.shifter = shiftIn(st_reg.shifter, cfg.shiftDirection,
                                    dataIn);
        end
        // data pin moves only on shift edges, so the far side never
        // sees it change together with its sampling edge
        if (shiftEdge) begin
          st_next.txBit = outBit(st_reg.shifter, cfg.shiftDirection);
        end
        // sixteen clock edges make one byte; the last one still counts
        if (st_next.edges == 5'h10 || (!isMaster && !slvSel)) begin
          st_next.state = SPMP_DONE;
        end
        // a role change mid-frame abandons the frame instead of
        // running it on with stale counters
        if (isMaster != st_reg.masterOn) begin
          st_next.state = SPMP_IDLE;
        end
      end
      SPMP_DONE: begin
        st_next.sck   = 1'b0;
        st_next.sel   = `SPMP_SEL_IDLE;
        if (st_reg.edges == 5'h0 && !isMaster) begin
          st_next.state = SPMP_IDLE;
        end else begin
          st_next.rxBuf  = st_reg.shifter;
          st_next.rxFull = 1'b1;
          st_next.edges  = 5'h0;
          st_next.state  = isMaster ? SPMP_IDLE : SPMP_DONE;
          if (!isMaster && !slvSel) begin
            st_next.state = SPMP_IDLE;
          end
        end
      end
      default: st_next.state = SPMP_IDLE;
    endcase
    // fault input drops master operation
    if (en && isMaster && cfg.modeFaultEnable &&
        !cfg.selectOutputEnable && !selIn) begin
      st_next.fault = 1'b1;
      st_next.state = SPMP_IDLE;
    end
    st_next.masterOn = en & isMaster;
    if (!en) begin
      st_next.state  = SPMP_IDLE;
      st_next.txFull = 1'b0;
      st_next.rxFull = 1'b0;
      st_next.txBuf  = 8'h00;
      st_next.rxBuf  = 8'h00;
      st_next.edges  = 5'h0;
      st_next.sck    = 1'b0;
      st_next.sel    = `SPMP_SEL_IDLE;
    end
    st_next.irq = (cfg.receiveFaultIrqEnable &
                   (st_next.rxFull | st_next.fault)) |
                  (cfg.transmitIrqEnable & ~st_next.txFull);
    // pin mux; output enables are active low
    st_next.outPins = 8'hff;
    if (en) begin
      if (isMaster) begin
        st_next.outPins[0] = st_next.sck ^ cfg.clockPolarity;
        st_next.outPins[1] = 1'b0;
        st_next.outPins[2] = st_next.txBit;
        st_next.outPins[3] = cfg.singleWireSelect & ~cfg.bidirOutputEnable;
        st_next.outPins[5] = ~(cfg.modeFaultEnable &
                               cfg.selectOutputEnable);
        st_next.outPins[4] = st_next.sel;
      end else begin
        st_next.outPins[2] = st_next.txBit;
        st_next.outPins[3] = ~slvSel |
                             (cfg.singleWireSelect &
                              ~cfg.bidirOutputEnable);
        st_next.outPins[4] = 1'b1;
      end
    end
  end

  // deep stop wake and rst_n both land in the reset state; light stop
  // drops the frame and clears both data buffers and full flags, as the port is gated off
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg        <= '0;
      st_reg.state  <= SPMP_IDLE;
      st_reg.sck    <= 1'b0;
      st_reg.sel    <= `SPMP_SEL_IDLE;
      st_reg.outPins <= 8'hff;
    end else if (deepStopWake) begin
      st_reg        <= '0;
      st_reg.state  <= SPMP_IDLE;
      st_reg.sel    <= `SPMP_SEL_IDLE;
      st_reg.outPins <= 8'hff;
    end else begin
      st_reg <= st_next;
    end
  end

  logic dataOut;
  logic dataOe_n;
  assign dataOut  = st_reg.outPins[2];
  assign dataOe_n = st_reg.outPins[3];

  always_comb begin
    rxData            = st_reg.rxBuf;
    receiveFullFlag   = st_reg.rxFull;
    transmitEmptyFlag = ~st_reg.txFull;
    modeFaultFlag     = st_reg.fault;
    masterActive      = st_reg.masterOn;
    irqReq            = st_reg.irq;
    sckOut            = st_reg.outPins[0];
    sckOe_n           = st_reg.outPins[1];
    selOut            = st_reg.outPins[4];
    selOe_n           = st_reg.outPins[5];
    mosiOut           = dataOut;
    misoOut           = dataOut;
    // master owns mosi, slave owns miso; single wire flips direction
    mosiOe_n = st_reg.masterOn ? dataOe_n : 1'b1;
    misoOe_n = st_reg.masterOn ? 1'b1 : dataOe_n;
  end
endmodule

//--- verification/spmp_port_monitor.sv
// Purpose: concurrent checks on the serial port pins and flags
// Assumes: pin enables are registered, so pin checks wait two cycles
// Notes:   only master-side timing is covered by the bench stimulus
`timescale 1ns/10ps
module spmp_port_monitor
  import spmp_pkg::*;
(
  input wire logic                core_clk,
  input wire logic                rst_n,
  input wire spmp_pkg::spmp_cfg_s cfg,
  input wire logic                stopMode,
  input wire logic                selIn,
  input wire logic                receiveFullFlag,
  input wire logic                transmitEmptyFlag,
  input wire logic                modeFaultFlag,
  input wire logic                masterActive,
  input wire logic                irqReq,
  input wire logic                sckOe_n,
  input wire logic                mosiOe_n,
  input wire logic                misoOe_n,
  input wire logic                selOe_n
);
  logic on;
  logic allOff;
  logic ma;
  assign on = cfg.portEnable && !stopMode;
  assign allOff = sckOe_n && mosiOe_n && misoOe_n && selOe_n;
  assign ma = on && masterActive;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_off; (!on)[*2] |-> allOff; endproperty
  a_off: assert property (p_off)
    else $error("pin driven while port off");
  property p_mst;
    (ma && !cfg.singleWireSelect)[*2] |-> misoOe_n && !sckOe_n;
  endproperty
  a_mst: assert property (p_mst)
    else $error("master pin directions wrong");
  property p_slv;
    (on && !cfg.masterSelect)[*2] |-> sckOe_n && mosiOe_n;
  endproperty
  a_slv: assert property (p_slv)
    else $error("slave drives clock or mosi");
  property p_desel;
    (on && !cfg.masterSelect && selIn)[*2] |-> misoOe_n;
  endproperty
  a_desel: assert property (p_desel)
    else $error("deselected slave drives miso");
  property p_gpio;
    (ma && !cfg.modeFaultEnable)[*2] |-> selOe_n;
  endproperty
  a_gpio: assert property (p_gpio)
    else $error("select pin driven without fault enable");
  property p_bidir;
    (ma && cfg.singleWireSelect && !cfg.bidirOutputEnable)[*2] |-> mosiOe_n;
  endproperty
  a_bidir: assert property (p_bidir)
    else $error("single wire input still driven");
  property p_fall;
    $fell(cfg.portEnable) |-> ##[1:2] transmitEmptyFlag && !receiveFullFlag;
  endproperty
  a_fall: assert property (p_fall)
    else $error("flags not reset on disable");
  property p_irq;
    on && receiveFullFlag && cfg.receiveFaultIrqEnable |-> ##[0:1] irqReq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("no interrupt on receive full");
  property p_fault;
    ma && cfg.modeFaultEnable && !cfg.selectOutputEnable && !selIn
      |-> ##[1:3] modeFaultFlag && !masterActive;
  endproperty
  a_fault: assert property (p_fault)
    else $error("mode fault not taken");
endmodule

bind spmp_port spmp_port_monitor spmp_port_monitor_i (.core_clk(core_clk),
  .rst_n(rst_n), .cfg(cfg), .stopMode(stopMode), .selIn(selIn),
  .receiveFullFlag(receiveFullFlag), .transmitEmptyFlag(transmitEmptyFlag),
  .modeFaultFlag(modeFaultFlag), .masterActive(masterActive), .irqReq(irqReq),
  .sckOe_n(sckOe_n), .mosiOe_n(mosiOe_n), .misoOe_n(misoOe_n),
  .selOe_n(selOe_n));

//--- verification/spmp_slave_model.sv
// Purpose: behavioural external slave on the serial wires
// Assumes: mode and bit order follow the port's own settings
// Notes:   deselected it shows the inverse bit, so stale data never matches
`timescale 1ns/10ps
module spmp_slave_model (
  input  wire logic       sck,
  input  wire logic       sel_n,
  input  wire logic       mosi,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       lsb,
  input  wire logic [7:0] txByte,
  output logic            miso,
  output logic [7:0]      rxByte
);
  logic [3:0] cnt = 4'h0;
  logic [2:0] idx = 3'h0;
  logic       cur;
  always @(negedge sel_n) begin
    cnt = 4'h0;
    idx = 3'h0;
  end
  always @(sck) if (!sel_n) begin
    if (sck == (cpol ~^ cpha)) begin
      rxByte = lsb ? {mosi, rxByte[7:1]} : {rxByte[6:0], mosi};
      cnt = cnt + 4'h1;
    end else
      idx = cnt[2:0];
  end
  assign cur = txByte[lsb ? idx : 3'h7 - idx];
  assign miso = sel_n ? ~cur : cur;
endmodule

//--- verification/test_spmp_port.sv
// Purpose: self-checking bench for the serial port block
// Assumes: external slave model on the wires, pull-up on idle mosi, idle sck held at clock polarity
// Notes:   slave mode is checked at pin level only
`timescale 1ns/10ps
module test_spmp_port;
  import spmp_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  spmp_cfg_s  cfg = '0;
  logic       stopMode = 1'b0, deepStopWake = 1'b0, txWrite = 1'b0;
  logic       rxRead = 1'b0, faultClear = 1'b0, tbSel = 1'b1;
  logic [7:0] txData = 8'h00, slvTx = 8'h00, rxData, slvRx;
  logic       rf, te, mf, ma, irq, sckO, sckOe_n, mosiO, mosiOe_n;
  logic       misoO, misoOe_n, selO, selOe_n, slvMiso;
  int         errTotal = 0, checks = 0;
  wire sckW = sckOe_n ? cfg.clockPolarity : sckO;
  wire mosiW = mosiOe_n ? 1'b1 : mosiO;
  wire misoW = misoOe_n ? slvMiso : misoO;
  wire selW = selOe_n ? tbSel : selO;
  always #20 core_clk = ~core_clk;
  spmp_port spmp_port_i (.core_clk(core_clk), .rst_n(rst_n), .cfg(cfg),
    .stopMode(stopMode), .deepStopWake(deepStopWake), .txWrite(txWrite),
    .txData(txData), .rxRead(rxRead), .faultClear(faultClear),
    .rxData(rxData), .receiveFullFlag(rf), .transmitEmptyFlag(te),
    .modeFaultFlag(mf), .masterActive(ma), .irqReq(irq), .sckIn(sckW),
    .sckOut(sckO), .sckOe_n(sckOe_n), .mosiIn(mosiW), .mosiOut(mosiO),
    .mosiOe_n(mosiOe_n), .misoIn(misoW), .misoOut(misoO),
    .misoOe_n(misoOe_n), .selIn(selW), .selOut(selO), .selOe_n(selOe_n));
  spmp_slave_model spmp_slave_model_i (.sck(sckW), .sel_n(selW),
    .mosi(mosiW), .cpol(cfg.clockPolarity), .cpha(cfg.clockPhase),
    .lsb(cfg.shiftDirection), .txByte(slvTx), .miso(slvMiso), .rxByte(slvRx));
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errTotal++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic setMode(input logic [6:0] v);
    {cfg.portEnable, cfg.masterSelect, cfg.singleWireSelect,
     cfg.bidirOutputEnable, cfg.modeFaultEnable, cfg.selectOutputEnable,
     tbSel} = v;
    tick(3);
  endtask
  task automatic t_pins;
    // enable, master, single wire, dir, fault en, sel out, sel pin, enables
    logic [10:0] tbl [9] = '{11'h21f, 11'h613, 11'h717, 11'h793, 11'h672,
                             11'h41f, 11'h40d, 11'h58d, 11'h50f};
    foreach (tbl[i]) begin
      setMode(tbl[i][10:4]);
      cmp({4'h0, sckOe_n, mosiOe_n, misoOe_n, selOe_n},
          {4'h0, tbl[i][3:0]});
      cmp({7'h0, ma}, {7'h0, tbl[i][10] & tbl[i][9]});
    end
    $display("done pin functions");
  endtask
  task automatic t_xfer(input logic [2:0] m);
    int n;
    int t;
    n = 0;
    t = 16 * (m + 1) * (1 << m[1:0]);
    {cfg.clockPolarity, cfg.clockPhase, cfg.shiftDirection} = m;
    cfg.prescaleSelect = m;
    cfg.rateSelect = {1'b0, m[1:0]};
    cfg.receiveFaultIrqEnable = 1'b1;
    setMode(7'h67);
    txData = 8'ha5 ^ {5'h0, m};
    slvTx = ~txData;
    txWrite = 1'b1;
    tick(1);
    txWrite = 1'b0;
    while (rf !== 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
    cmp(rxData, slvTx);
    cmp(slvRx, txData);
    cmp({7'h0, n >= t - 2 && n <= t + 6}, 8'h01);
    cmp({7'h0, sckW}, {7'h0, m[2]});
    tick(1);
    cmp({7'h0, irq}, 8'h01);
    rxRead = 1'b1;
    tick(1);
    rxRead = 1'b0;
    tick(1);
    cmp({7'h0, rf}, 8'h00);
    $display("done transfer mode %0d", m);
  endtask
  task automatic t_off;
    txWrite = 1'b1;
    tick(1);
    txWrite = 1'b0;
    tick(20);
    cfg.portEnable = 1'b0;
    tick(3);
    cmp({4'h0, sckOe_n, mosiOe_n, misoOe_n, selOe_n}, 8'h0f);
    cmp({6'h0, te, rf}, 8'h02);
    cfg.portEnable = 1'b1;
    stopMode = 1'b1;
    tick(3);
    cmp({4'h0, sckOe_n, mosiOe_n, misoOe_n, selOe_n}, 8'h0f);
    stopMode = 1'b0;
    deepStopWake = 1'b1;
    tick(1);
    deepStopWake = 1'b0;
    tick(3);
    cmp({5'h0, te, rf, mf}, 8'h04);
    $display("done disable and stop");
  endtask
  task automatic t_fault;
    setMode(7'h65);
    tbSel = 1'b0;
    tick(4);
    cmp({6'h0, mf, ma}, 8'h02);
    cmp({7'h0, irq}, 8'h01);
    tbSel = 1'b1;
    faultClear = 1'b1;
    tick(1);
    faultClear = 1'b0;
    tick(2);
    cmp({7'h0, mf}, 8'h00);
    $display("done mode fault");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    tick(12);
    rst_n = 1'b1;
    tick(1);
    cmp({5'h0, te, rf, mf}, 8'h04);
    t_pins();
    for (int m = 0; m < 8; m++)
      t_xfer(m[2:0]);
    t_off();
    t_fault();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errTotal++;
    report_and_stop();
  end
endmodule
